// [pkg/fifo_path_pkg.sv]
// Purpose: Constants and carrier types for the data FIFO path control block.
// Assumes: 8-bit registers in the low byte lane of a 32-bit AXI4-Lite word.
// Notes:   Offsets are byte addresses; field positions are bit indices.
// Operation
// - SCSI transfer enable permits bus transfers; clearing it stops further ACKs.
// - Enable bits read back real hardware state; software polls until zero.
// - Synchronous data-in always permitted with nonzero offset in data-in phase.
// - SCSI DMA enable permits byte movement between SCSI block and FIFO.
// - Host DMA enable moves data; clearing it halts but keeps data and count.
// - Direction 1 fills from PCI or sequencer; 0 fills from SCSI or sequencer.
// - With both DMA acks low the sequencer may read and write either way.
// - Acknowledged direction changes only once all three enables are clear.
// - Flush pushes leftover bytes to memory; ignored if empty, or if PCI-to-SCSI while either DMA ack is set.
// - Hardware flushes on SCSI count zero or phase change in direction 0 unless disabled.
// - Flush bit reads 1 while any flush is pending or running.
// - Flush after sequencer writes makes blocks accept a partial quad word.
// - FIFO clear empties status, self-clears and loads byte offset pointers.
// - Line threshold flag follows line size: 32/16, 32/32 or 64/64 bytes.
// - Resets drop line threshold flag; FIFO clear forces it to direction.
// - Quad word empty stays 1 below eight stored bytes; resets force it.
// - Memory request pending set by threshold or done/flush; cleared by stop.
// - Level flag on quad word count match; bus request needs host DMA ack and master enable.
// - Host done set after host count zero and final transfer completes.
// - Full when every slot used, empty when none; resets force empty.
// - All control bits forced to zero by bus reset or soft chip reset.
package fifo_path_pkg;

  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  STAT_OFS      = 8'h94;
  localparam logic [7:0]  CTRL_OFS      = 8'h98;
  localparam logic [7:0]  CFG_OFS       = 8'h9C;

  // Control register fields
  localparam int          C_WIDE_ODD    = 6;
  localparam int          C_SCSI_EN     = 5;
  localparam int          C_SDMA_EN     = 4;
  localparam int          C_HDMA_EN     = 3;
  localparam int          C_DIR         = 2;
  localparam int          C_DRAIN       = 1;
  localparam int          C_CLEAR       = 0;

  // Status register fields
  localparam int          S_LINE        = 6;
  localparam int          S_QWE         = 5;
  localparam int          S_MREQ        = 4;
  localparam int          S_HOST_DONE       = 3;
  localparam int          S_LEVEL       = 2;
  localparam int          S_FULL        = 1;
  localparam int          S_EMPTY       = 0;

  // Configuration register fields
  localparam int          G_LVL_LSB     = 0;
  localparam int          G_AUTO_OFF    = 2;

  localparam logic [7:0]  STAT_RESET    = 8'h21;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h00;

  // Burst need in bytes by line size
  localparam logic [7:0]  LINE_MID_MIN  = 8'h08;
  localparam logic [7:0]  LINE_BIG_MIN  = 8'h10;
  localparam logic [7:0]  FILL_SMALL    = 8'h20;
  localparam logic [7:0]  DRAIN_SMALL   = 8'h10;
  localparam logic [7:0]  NEED_MID      = 8'h20;
  localparam logic [7:0]  NEED_BIG      = 8'h40;

  // Quad words per level selection
  localparam logic [7:0]  LEVEL_QW0     = 8'h01;
  localparam logic [7:0]  LEVEL_QW1     = 8'h02;
  localparam logic [7:0]  LEVEL_QW2     = 8'h04;
  localparam logic [7:0]  LEVEL_QW3     = 8'h08;
  localparam int          QW_SHIFT      = 3;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    DRAIN_IDLE = 2'b01,
    DRAIN_BUSY = 2'b10
  } drain_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic       host_wr_valid;
    logic [7:0] host_wr_data;
    logic       host_rd_req;
    logic       scsi_wr_valid;
    logic [7:0] scsi_wr_data;
    logic       scsi_rd_req;
    logic       seq_wr;
    logic [7:0] seq_wr_data;
    logic       seq_rd;
    logic       scsi_busy;
    logic       host_busy;
    logic       sync_offset_nz;
    logic       data_in_phase;
    logic       scsi_phase_change;
    logic       scsi_count_zero;
    logic       scsi_xfer_done;
    logic       host_count_zero;
    logic       master_enable;
    logic       recv_master_abort;
    logic       recv_target_abort;
    logic [7:0] line_size;
    logic [2:0] low_host_addr;
  } side_in_t;

  typedef struct packed {
    logic [7:0] rd_data;
    logic       host_rd_valid;
    logic       scsi_rd_valid;
    logic       seq_rd_valid;
    logic [2:0] wr_taken;
    logic       scsi_xfer_permit;
    logic       scsi_dma_run;
    logic       host_dma_run;
    logic       path_dir;
    logic [2:0] byte_offset;
    logic       offset_load;
    logic       partial_accept;
    logic       line_thresh_ok;
    logic       qword_empty;
    logic       mem_req_pending;
    logic       host_done;
    logic       level_thresh_hit;
    logic       fifo_full_a;
    logic       fifo_empty;
    logic       bus_request_pin_n;
  } side_out_t;

endpackage : fifo_path_pkg

// [rtl/data_fifo_path_control.sv]
// Purpose: Data FIFO storage, path enables, flush and PCI request control.
// Assumes: All side inputs come from logic on aclk; soft_chip_reset is a level.
// Notes:   Soft chip reset clears the path but leaves a bus transfer intact.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module data_fifo_path_control
  import fifo_path_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      ce,
  input  wire logic      soft_chip_reset,
  input  wire axi_req_t  axi_in,
  output var  axi_rsp_t  axi_out,
  input  wire side_in_t  side_in,
  output var  side_out_t side_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [7:0]        w_data;
    logic              w_lane;
    axi_rsp_t          axo;
  } bus_t;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         wptr;
    logic [AW-1:0]         rptr;
    logic [CW-1:0]         count;
    logic                  wide_odd;
    logic                  scsi_en;
    logic                  sdma_en;
    logic                  hdma_en;
    logic                  dir_req;
    logic                  scsi_ack;
    logic                  sdma_ack;
    logic                  hdma_ack;
    drain_state_t          drain;
    logic [1:0]            lvl_sel;
    logic                  auto_off;
    bus_t                  bus;
    side_out_t             so;
  } state_t;

  // Known register offsets
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == STAT_OFS) || (a == CTRL_OFS) || (a == CFG_OFS);
  endfunction : reg_hit

  // Bytes of space or data needed for one burst
  function automatic logic [7:0] burst_need(input logic [7:0] line, input logic filling);
    if (line >= LINE_BIG_MIN) begin
      burst_need = NEED_BIG;
    end else if (line >= LINE_MID_MIN) begin
      burst_need = NEED_MID;
    end else begin
      burst_need = filling ? FILL_SMALL : DRAIN_SMALL;
    end
  endfunction : burst_need

  // Quad word level per selection
  function automatic logic [7:0] level_qw(input logic [1:0] sel);
    case (sel)
      2'h0:    level_qw = LEVEL_QW0;
      2'h1:    level_qw = LEVEL_QW1;
      2'h2:    level_qw = LEVEL_QW2;
      default: level_qw = LEVEL_QW3;
    endcase
  endfunction : level_qw

  // Reset image
  function automatic state_t rst_state();
    state_t s;
    s                      = '0;
    s.drain                = DRAIN_IDLE;
    s.so.qword_empty       = STAT_RESET[S_QWE];
    s.so.fifo_empty        = STAT_RESET[S_EMPTY];
    s.so.fifo_full_a       = STAT_RESET[S_FULL];
    s.so.line_thresh_ok    = STAT_RESET[S_LINE];
    s.so.bus_request_pin_n = 1'b1;
    s.wide_odd             = CTRL_RESET[C_WIDE_ODD];
    s.lvl_sel              = CFG_RESET[G_LVL_LSB +: 2];
    s.auto_off             = CFG_RESET[G_AUTO_OFF];
    return s;
  endfunction : rst_state

  state_t r;
  state_t n;

  // Next state of the whole block
  always_comb begin
    logic          wr_ctrl;
    logic          wr_cfg;
    logic          drain_req;
    logic          clear_req;
    logic          permit;
    logic          seq_ok;
    logic          full;
    logic          empty;
    logic [2:0]    wsel;
    logic [2:0]    rsel;
    logic          do_wr;
    logic          do_rd;
    logic [7:0]    wdata;
    logic [7:0]    ctrl_rd;
    logic [7:0]    stat_rd;
    logic [7:0]    cfg_rd;
    logic [7:0]    rd_byte;
    logic          drain_go;
    logic          mreq_set;
    logic          mreq_stop;
    logic          bus_ok;
    logic [CW-1:0] space;
    bus_t          keep;
    wr_ctrl   = 1'b0;
    wr_cfg    = 1'b0;
    drain_req = 1'b0;
    clear_req = 1'b0;
    wdata     = 8'h00;
    rd_byte   = 8'h00;
    keep      = r.bus;
    n         = r;
    n.so.host_rd_valid = 1'b0;
    n.so.scsi_rd_valid = 1'b0;
    n.so.seq_rd_valid  = 1'b0;
    n.so.wr_taken      = 3'h0;
    n.so.offset_load   = 1'b0;

    // Register images
    ctrl_rd = {1'b0, r.wide_odd, r.scsi_ack, r.sdma_ack, r.hdma_ack, r.so.path_dir,
               (r.drain == DRAIN_BUSY), 1'b0};
    stat_rd = {1'b0, r.so.line_thresh_ok, r.so.qword_empty, r.so.mem_req_pending,
               r.so.host_done, r.so.level_thresh_hit, r.so.fifo_full_a, r.so.fifo_empty};
    cfg_rd  = {5'h00, r.auto_off, r.lvl_sel};

    // Write address and data are taken in either order
    if (axi_in.awvalid && r.bus.axo.awready) begin
      n.bus.aw_got  = 1'b1;
      n.bus.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && r.bus.axo.wready) begin
      n.bus.w_got  = 1'b1;
      n.bus.w_data = axi_in.wdata[7:0];
      n.bus.w_lane = axi_in.wstrb[0];
    end
    if (r.bus.aw_got && r.bus.w_got && !r.bus.axo.bvalid) begin
      n.bus.aw_got    = 1'b0;
      n.bus.w_got     = 1'b0;
      n.bus.axo.bvalid = 1'b1;
      n.bus.axo.bresp  = reg_hit(r.bus.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      wr_ctrl = r.bus.w_lane && (r.bus.aw_addr == CTRL_OFS);
      wr_cfg  = r.bus.w_lane && (r.bus.aw_addr == CFG_OFS);
    end else if (r.bus.axo.bvalid && axi_in.bready) begin
      n.bus.axo.bvalid = 1'b0;
    end

    // Read answers one cycle after the address is taken
    if (axi_in.arvalid && r.bus.axo.arready) begin
      n.bus.axo.rvalid = 1'b1;
      n.bus.axo.rresp  = reg_hit(axi_in.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (axi_in.araddr)
        STAT_OFS: n.bus.axo.rdata = {24'h000000, stat_rd};
        CTRL_OFS: n.bus.axo.rdata = {24'h000000, ctrl_rd};
        CFG_OFS:  n.bus.axo.rdata = {24'h000000, cfg_rd};
        default:  n.bus.axo.rdata = 32'h00000000;
      endcase
    end else if (r.bus.axo.rvalid && axi_in.rready) begin
      n.bus.axo.rvalid = 1'b0;
    end
    // One transfer each way at a time
    n.bus.axo.awready = !n.bus.aw_got && !n.bus.axo.bvalid;
    n.bus.axo.wready  = !n.bus.w_got && !n.bus.axo.bvalid;
    n.bus.axo.arready = !n.bus.axo.rvalid;

    // Software writes; flush and clear are one-shot requests
    if (wr_ctrl) begin
      n.wide_odd = r.bus.w_data[C_WIDE_ODD];
      n.scsi_en  = r.bus.w_data[C_SCSI_EN];
      n.sdma_en  = r.bus.w_data[C_SDMA_EN];
      n.hdma_en  = r.bus.w_data[C_HDMA_EN];
      n.dir_req  = r.bus.w_data[C_DIR];
      drain_req  = r.bus.w_data[C_DRAIN];
      clear_req  = r.bus.w_data[C_CLEAR];
      if (r.bus.w_data[C_HDMA_EN] && !r.hdma_en) begin
        n.so.host_done = 1'b0;
      end
    end
    if (wr_cfg) begin
      n.lvl_sel  = r.bus.w_data[G_LVL_LSB +: 2];
      n.auto_off = r.bus.w_data[G_AUTO_OFF];
    end

    // Acks drop only once the engine behind them is idle
    n.scsi_ack = n.scsi_en || (r.scsi_ack && side_in.scsi_busy);
    n.sdma_ack = n.sdma_en || (r.sdma_ack && side_in.scsi_busy);
    n.hdma_ack = n.hdma_en || (r.hdma_ack && side_in.host_busy);
    if (!n.scsi_en && !n.sdma_en && !n.hdma_en &&
        !n.scsi_ack && !n.sdma_ack && !n.hdma_ack) begin
      n.so.path_dir = n.dir_req;
    end

    // Path permissions from the present enables and acks
    permit = r.scsi_en || (side_in.sync_offset_nz && side_in.data_in_phase);
    seq_ok = !r.hdma_ack && !r.sdma_ack;
    full   = (r.count == CW'(DEPTH));
    empty  = (r.count == '0);

    // Filling side: host on direction 1, SCSI on direction 0
    wsel = 3'h0;
    if (r.hdma_ack && r.so.path_dir && side_in.host_wr_valid) begin
      wsel  = 3'h1;
      wdata = side_in.host_wr_data;
    end else if (r.sdma_ack && !r.so.path_dir && side_in.scsi_wr_valid && permit) begin
      wsel  = 3'h2;
      wdata = side_in.scsi_wr_data;
    end else if (seq_ok && side_in.seq_wr) begin
      wsel  = 3'h4;
      wdata = side_in.seq_wr_data;
    end
    do_wr = (wsel != 3'h0) && !full;

    // Draining side mirrors the filling side
    rsel = 3'h0;
    if (r.hdma_ack && !r.so.path_dir && side_in.host_rd_req) begin
      rsel = 3'h1;
    end else if (r.sdma_ack && r.so.path_dir && side_in.scsi_rd_req && r.scsi_en) begin
      rsel = 3'h2;
    end else if (seq_ok && side_in.seq_rd) begin
      rsel = 3'h4;
    end
    do_rd = (rsel != 3'h0) && !empty;
    if (do_rd) begin
      rd_byte = r.mem[r.rptr];
    end

    // One slot per byte keeps partial words
    if (do_wr) begin
      n.mem[r.wptr] = wdata;
      n.wptr        = r.wptr + 1'b1;
      n.so.wr_taken = wsel;
    end
    if (do_rd) begin
      n.so.rd_data       = rd_byte;
      n.rptr             = r.rptr + 1'b1;
      n.so.host_rd_valid = rsel[0];
      n.so.scsi_rd_valid = rsel[1];
      n.so.seq_rd_valid  = rsel[2];
    end
    n.count = r.count + CW'(do_wr) - CW'(do_rd);

    // Manual and automatic flush
    drain_go = (drain_req && !empty && (!r.so.path_dir || seq_ok)) ||
               (!r.auto_off && !r.so.path_dir && !empty &&
                (side_in.scsi_count_zero || side_in.scsi_phase_change));
    case (r.drain)
      DRAIN_IDLE: begin
        if (drain_go) begin
          n.drain = DRAIN_BUSY;
        end
      end
      DRAIN_BUSY: begin
        if (empty && !side_in.host_busy) begin
          n.drain = DRAIN_IDLE;
        end
      end
      default: begin
        n.drain = DRAIN_IDLE;
      end
    endcase
    n.so.partial_accept = (n.drain == DRAIN_BUSY);

    // Memory request and host completion
    mreq_set  = r.hdma_ack && (r.so.level_thresh_hit ||
                ((side_in.scsi_xfer_done || r.drain == DRAIN_BUSY) && !r.so.qword_empty));
    mreq_stop = side_in.host_count_zero || (!r.so.path_dir && empty) ||
                (r.so.path_dir && full) || !r.hdma_en || r.so.host_done;
    if (mreq_stop) begin
      n.so.mem_req_pending = 1'b0;
    end else if (mreq_set) begin
      n.so.mem_req_pending = 1'b1;
    end
    if (r.hdma_ack && side_in.host_count_zero && !side_in.host_busy) begin
      n.so.host_done = 1'b1;
    end

    // FIFO clear empties the path and loads the byte offset
    if (clear_req) begin
      n.count              = '0;
      n.wptr               = AW'(side_in.low_host_addr);
      n.rptr               = AW'(side_in.low_host_addr);
      n.drain              = DRAIN_IDLE;
      n.so.mem_req_pending = 1'b0;
      n.so.byte_offset     = side_in.low_host_addr;
      n.so.offset_load     = 1'b1;
    end

    // Flags from the next count
    space                 = CW'(DEPTH) - n.count;
    n.so.fifo_full_a      = (n.count == CW'(DEPTH));
    n.so.fifo_empty       = (n.count == '0);
    n.so.qword_empty      = (n.count < CW'(8));
    n.so.level_thresh_hit = ((n.count >> QW_SHIFT) == CW'(level_qw(n.lvl_sel)));
    n.so.line_thresh_ok   = n.so.path_dir ?
                            (space >= CW'(burst_need(side_in.line_size, 1'b1))) :
                            (n.count >= CW'(burst_need(side_in.line_size, 1'b0)));
    if (clear_req) begin
      n.so.line_thresh_ok = n.so.path_dir;
    end

    // Bus request gating
    bus_ok = n.so.mem_req_pending && n.hdma_ack && !side_in.host_count_zero &&
             side_in.master_enable && !side_in.recv_master_abort &&
             !side_in.recv_target_abort;
    n.so.bus_request_pin_n = !bus_ok;
    n.so.scsi_xfer_permit  = n.scsi_en || (side_in.sync_offset_nz && side_in.data_in_phase);
    n.so.scsi_dma_run      = n.sdma_ack;
    n.so.host_dma_run      = n.hdma_ack;

    // Soft chip reset clears the path, not the bus slave
    if (soft_chip_reset) begin
      keep  = n.bus;
      n     = rst_state();
      n.bus = keep;
    end
  end

  // Single state register, frozen while ce is low and aresetn is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= rst_state();
    end else if (ce) begin
      r <= n;
    end
  end

  assign axi_out  = r.bus.axo;
  assign side_out = r.so;

endmodule : data_fifo_path_control

`default_nettype wire

// [testbench/far_side_model.sv]
// Purpose: Host block, SCSI block and sequencer facing the FIFO path.
// Assumes: Caller knows the stored byte count and asks only what fits.
// Notes:   Released data lines flip to the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import fifo_path_pkg::*;
(
  input  wire logic      aclk,
  input  wire side_out_t so,
  output var  side_in_t  si
);
  logic [7:0] got_q[$];

  initial si = '0;

  // Collect every byte read
  always @(posedge aclk) begin
    if (so.host_rd_valid || so.scsi_rd_valid || so.seq_rd_valid) got_q.push_back(so.rd_data);
  end

  // src 0 host, 1 scsi, 2 sequencer
  task push(input int src, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      si.host_wr_valid <= (src == 0);
      si.scsi_wr_valid <= (src == 1);
      si.seq_wr        <= (src == 2);
      si.host_wr_data  <= b0 + i[7:0];
      si.scsi_wr_data  <= b0 + i[7:0];
      si.seq_wr_data   <= b0 + i[7:0];
    end
    @(posedge aclk);
    si.host_wr_valid <= 1'b0;
    si.scsi_wr_valid <= 1'b0;
    si.seq_wr        <= 1'b0;
    si.host_wr_data  <= ~si.host_wr_data;
    si.scsi_wr_data  <= ~si.scsi_wr_data;
    si.seq_wr_data   <= ~si.seq_wr_data;
  endtask : push

  // Ask for n stored bytes
  task pull(input int src, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      si.host_rd_req <= (src == 0);
      si.scsi_rd_req <= (src == 1);
      si.seq_rd      <= (src == 2);
    end
    @(posedge aclk);
    si.host_rd_req <= 1'b0;
    si.scsi_rd_req <= 1'b0;
    si.seq_rd      <= 1'b0;
    // Two extra edges so the last byte is collected before return
    repeat (2) @(posedge aclk);
  endtask : pull
endmodule : far_side_model
`default_nettype wire

// [testbench/fifo_path_chk.sv]
// Purpose: Port-level assertions for the data FIFO path control block.
// Assumes: ce held high by the bench; side inputs are same-clock levels.
// Notes:   Sees only the top ports; attached by bind from the bench top.
`timescale 1ns/1ps
`default_nettype none
module fifo_path_chk
  import fifo_path_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      ce,
  input wire logic      soft_chip_reset,
  input wire axi_req_t  axi_in,
  input wire axi_rsp_t  axi_out,
  input wire side_in_t  side_in,
  input wire side_out_t side_out
);
  default clocking @(posedge aclk); endclocking

  // Reset values one edge on
  a_reset_flags: assert property (!aresetn && ce |=> side_out.fifo_empty && side_out.qword_empty
    && !side_out.fifo_full_a && side_out.bus_request_pin_n) else $error("reset flags wrong");
  a_soft_clear: assert property (disable iff (!aresetn) soft_chip_reset && ce |=>
    !side_out.host_dma_run && !side_out.line_thresh_ok && side_out.fifo_empty
    && !side_out.mem_req_pending) else $error("soft reset left path state");
  a_flag_excl: assert property (disable iff (!aresetn) !(side_out.fifo_full_a
    && (side_out.fifo_empty || side_out.qword_empty))) else $error("full with empty flag");
  // Direction may only move once both DMA acks are down
  a_dir_hold: assert property (disable iff (!aresetn) $changed(side_out.path_dir) |->
    !side_out.host_dma_run && !side_out.scsi_dma_run) else $error("direction moved under ack");
  a_offset_load: assert property (disable iff (!aresetn) side_out.offset_load |->
    side_out.byte_offset == $past(side_in.low_host_addr) && side_out.fifo_empty)
    else $error("offset load wrong");
  a_seq_read: assert property (disable iff (!aresetn) side_out.seq_rd_valid |->
    $past(side_in.seq_rd && !side_out.fifo_empty && !side_out.host_dma_run
    && !side_out.scsi_dma_run)) else $error("sequencer read without cause");
  a_seq_write: assert property (disable iff (!aresetn) side_out.wr_taken[2] |->
    $past(side_in.seq_wr && !side_out.fifo_full_a && !side_out.host_dma_run
    && !side_out.scsi_dma_run)) else $error("sequencer write without cause");
  a_host_done: assert property (disable iff (!aresetn) $rose(side_out.host_done) |->
    $past(side_in.host_count_zero && !side_in.host_busy)) else $error("host done early");
  a_req_gate: assert property (disable iff (!aresetn) !side_out.bus_request_pin_n |->
    $past(side_in.master_enable && !side_in.host_count_zero && !side_in.recv_master_abort
    && !side_in.recv_target_abort)) else $error("bus request not gated");
  a_rd_answer: assert property (disable iff (!aresetn) axi_in.arvalid && axi_out.arready
    |=> axi_out.rvalid) else $error("read answer late");

  c_offset: cover property (disable iff (!aresetn) side_out.offset_load);
  c_request: cover property (disable iff (!aresetn) !side_out.bus_request_pin_n);
  c_drain_end: cover property (disable iff (!aresetn) $fell(side_out.partial_accept));
endmodule : fifo_path_chk
`default_nettype wire

// [testbench/tb_data_fifo_path_control.sv]
// Purpose: Self-checking bench for the data FIFO path control block.
// Assumes: Registers over AXI4-Lite; far side held by far_side_model.
// Notes:   ce stays high, so clock-enable freezing is not exercised.
`timescale 1ns/1ps
`default_nettype none
module tb_data_fifo_path_control
  import fifo_path_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic        soft_chip_reset;
  axi_req_t    req;
  axi_rsp_t    rsp;
  side_in_t    si;
  side_out_t   so;
  int          err_total;
  int          checked;
  logic [31:0] rv;

  data_fifo_path_control #(.DEPTH(128)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .soft_chip_reset(soft_chip_reset), .axi_in(req), .axi_out(rsp), .side_in(si),
    .side_out(so));
  far_side_model u_far (.aclk(aclk), .so(so), .si(si));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a == STAT_OFS || a == CTRL_OFS || a == CFG_OFS) ? RESP_OKAY : RESP_SLVERR;
  endfunction : resp_of

  // AW and W offered together
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    req.awaddr  <= a;
    req.wdata   <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 64);
    req.bready <= 1'b0;
    chk({29'h0, rsp.bvalid, rsp.bresp}, {29'h0, 1'b1, resp_of(a)});
  endtask : wr

  task rd_raw(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 64);
    req.rready <= 1'b0;
    rv = rsp.rvalid ? rsp.rdata : 32'hFFFF_FFFF;
    chk({30'h0, rsp.rresp}, {30'h0, resp_of(a)});
  endtask : rd_raw

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_raw(a);
    chk(rv & {24'hFF_FFFF, m}, {24'h0, e & m});
  endtask : rd

  task t_reset;
    rd(STAT_OFS, STAT_RESET, 8'hFF);
    rd(CTRL_OFS, CTRL_RESET, 8'hFF);
    rd(CFG_OFS, CFG_RESET, 8'hFF);
    rd(8'hA0, 8'h00, 8'hFF);
    wr(8'hA0, 8'hFF);
    wr(STAT_OFS, 8'hFF);
    rd(STAT_OFS, STAT_RESET, 8'hFF);
    $display("t_reset done");
  endtask : t_reset

  task t_fill;
    wr(CTRL_OFS, 8'h04);
    u_far.push(2, 7, 8'h10);
    rd(STAT_OFS, 8'h60, 8'h67);
    u_far.push(2, 1, 8'h17);
    rd(STAT_OFS, 8'h44, 8'h67);
    u_far.push(2, 89, 8'h18);
    rd(STAT_OFS, 8'h00, 8'h67);
    u_far.push(2, 31, 8'h71);
    rd(STAT_OFS, 8'h02, 8'h67);
    u_far.got_q.delete();
    u_far.pull(2, 128);
    for (int i = 0; i < 128; i++) chk(u_far.got_q[i], 8'h10 + i);
    rd(STAT_OFS, 8'h61, 8'h67);
    $display("t_fill done");
  endtask : t_fill

  task t_clear;
    u_far.si.low_host_addr <= 3'h5;
    u_far.push(2, 3, 8'h20);
    wr(CTRL_OFS, 8'h05);
    rd(STAT_OFS, 8'h61, 8'h63);
    rd(CTRL_OFS, 8'h04, 8'h07);
    wr(CTRL_OFS, 8'h01);
    rd(STAT_OFS, 8'h21, 8'h63);
    $display("t_clear done");
  endtask : t_clear

  task t_flush;
    u_far.push(2, 9, 8'h40);
    wr(CTRL_OFS, 8'h02);
    rd(CTRL_OFS, 8'h02, 8'h02);
    chk(so.partial_accept, 1'b1);
    wr(CTRL_OFS, 8'h08);
    rd(STAT_OFS, 8'h10, 8'h10);
    chk(so.bus_request_pin_n, 1'b0);
    u_far.got_q.delete();
    u_far.pull(0, 9);
    for (int i = 0; i < 9; i++) chk(u_far.got_q[i], 8'h40 + i);
    rd(CTRL_OFS, 8'h08, 8'h0A);
    wr(CTRL_OFS, 8'h0A);
    rd(CTRL_OFS, 8'h08, 8'h0A);
    $display("t_flush done");
  endtask : t_flush

  task t_dir;
    u_far.si.host_count_zero <= 1'b1;
    rd(STAT_OFS, 8'h08, 8'h08);
    u_far.si.host_busy       <= 1'b1;
    u_far.si.host_count_zero <= 1'b0;
    wr(CTRL_OFS, 8'h0C);
    rd(CTRL_OFS, 8'h08, 8'h0C);
    wr(CTRL_OFS, 8'h04);
    rd(CTRL_OFS, 8'h08, 8'h0C);
    u_far.si.host_busy <= 1'b0;
    rd_raw(CTRL_OFS);
    // Software polls ack down
    for (int k = 0; k < 8 && rv[3]; k++) rd_raw(CTRL_OFS);
    chk(rv[3:2], 2'b01);
    $display("t_dir done");
  endtask : t_dir

  task t_scsi;
    wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h10);
    u_far.push(1, 1, 8'h55);
    rd(STAT_OFS, 8'h01, 8'h01);
    u_far.si.sync_offset_nz <= 1'b1;
    u_far.si.data_in_phase  <= 1'b1;
    u_far.push(1, 1, 8'h56);
    rd(STAT_OFS, 8'h00, 8'h01);
    u_far.si.sync_offset_nz <= 1'b0;
    wr(CTRL_OFS, 8'h30);
    chk(so.scsi_xfer_permit, 1'b1);
    wr(CTRL_OFS, 8'h10);
    repeat (2) @(posedge aclk);
    chk(so.scsi_xfer_permit, 1'b0);
    $display("t_scsi done");
  endtask : t_scsi

  task t_soft;
    @(posedge aclk);
    soft_chip_reset <= 1'b1;
    @(posedge aclk);
    soft_chip_reset <= 1'b0;
    rd(CTRL_OFS, 8'h00, 8'h7F);
    rd(STAT_OFS, 8'h21, 8'h7F);
    $display("t_soft done");
  endtask : t_soft

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Whole run is well under 5000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    req             = '0;
    req.wstrb       = 4'hF;
    ce              = 1'b1;
    soft_chip_reset = 1'b0;
    aresetn         = 1'b0;
    err_total       = 0;
    checked         = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    u_far.si.master_enable <= 1'b1;
    t_reset();
    t_fill();
    t_clear();
    t_flush();
    t_dir();
    t_scsi();
    t_soft();
    tally_and_finish();
  end
endmodule : tb_data_fifo_path_control

bind data_fifo_path_control fifo_path_chk #(.DEPTH(DEPTH)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .ce(ce), .soft_chip_reset(soft_chip_reset), .axi_in(axi_in),
  .axi_out(axi_out), .side_in(side_in), .side_out(side_out));
`default_nettype wire
